/* design/dos_consts.vh */
// Constants for the discrete output sequencer: register map, field positions,
// reset values, mode codes and timing figures.
// Assumes inclusion by its bare name from the sequencer design file.
`ifndef DOS_CONSTS_VH
`define DOS_CONSTS_VH

// Byte offsets of global registers
`define DOS_REG_FLASH      8'h00
`define DOS_REG_WDOG       8'h04
`define DOS_REG_PORT_EN    8'h08
`define DOS_REG_STATUS     8'h0C
`define DOS_REG_CMD        8'h10
// Per-channel block: base plus channel times stride
`define DOS_CH_BASE        4'h4
`define DOS_CH_CFG         4'h0
`define DOS_CH_ON          4'h4
`define DOS_CH_OFF         4'h8
`define DOS_CH_HOLD        4'hC

// Channel configuration fields
`define DOS_CFG_MODE_LSB   0
`define DOS_CFG_MODE_MSB   2
`define DOS_CFG_FORCE_LSB  4
`define DOS_CFG_FORCE_MSB  5
`define DOS_CFG_SRC        8
`define DOS_CFG_FAIL_LSB   12
`define DOS_CFG_FAIL_MSB   13
`define DOS_CFG_MASK       16'h313F

// Status fields
`define DOS_ST_FAIL        0
`define DOS_ST_PORT_LSB    8
`define DOS_ST_DOUT_LSB    16

// Output modes
`define DOS_MODE_DIRECT    3'h0
`define DOS_MODE_PWM       3'h1
`define DOS_MODE_DELAY     3'h2
`define DOS_MODE_FLASH     3'h3
`define DOS_MODE_TOGGLE    3'h4
`define DOS_MODE_OSALT     3'h5
`define DOS_MODE_PULSE     3'h6

// Force and link-loss action codes
`define DOS_FORCE_NONE     2'h0
`define DOS_FORCE_OFF      2'h1
`define DOS_FORCE_ON       2'h2
`define DOS_FAIL_HOLD      2'h0
`define DOS_FAIL_OFF       2'h1
`define DOS_FAIL_ON        2'h2

// Reset values
`define DOS_RST_FLASH      16'h0032
`define DOS_RST_WDOG       16'h0000
`define DOS_RST_CFG        16'h0000

// Timing
`define DOS_CLK_NS         50
`define DOS_TICK_NS        1000000
// One millisecond of 50 ns clocks, sized for the 16-bit tick counter
`define DOS_TICK_CYCLES    16'h4E20
`define DOS_FLASH_STEP_MS  4'h9

`endif

/* design/dos_sequencer.v */
// Discrete output sequencer: per-channel mode timing, force, holdoff,
// source select and link-loss states, with an AHB-Lite register slave.
// Assumes a single 20 MHz clock, one AHB-Lite master, message pulses per port.
//
// Operation
// - Force holds output, discards changing commands
// - Force setting kept per channel, bus writable
// - PWM alternates on and off while commanded
// - Delay mode waits, then on until off
// - Flash channels share one common timebase
// - Flash half period in ten millisecond steps
// - Flash setting gives equal on, off phases
// - Toggle modes invert on command rising edge
// - One-shot toggle flips, then off after time
// - Pulse waits off time, then on time
// - With command register source, pulse refires without an intervening off
// - New command during pulse restarts on time
// - Nonzero holdoff keeps output off after turnoff
// - No added delay once holdoff elapsed
// - Per channel link-loss action hold off on
// - Failure detection enabled per port
// - Failure states kept until host writes the command register
// - Source select picks function block result
// - Failure when timeout nonzero and silent
`include "dos_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module dos_sequencer #(
  parameter        NCH         = 4,
  parameter        NPORT       = 2,
  parameter [15:0] TICK_CYCLES = `DOS_TICK_CYCLES
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg              hreadyout,
  output reg  [31:0]      hrdata,
  output reg              hresp,
  input  wire [NPORT-1:0] msg_rx,
  input  wire [NCH-1:0]   fb_result,
  output wire [NCH-1:0]   dout,
  output reg              comm_fail
);

  localparam S_IDLE = 3'b001;
  localparam S_WAIT = 3'b010;
  localparam S_ON   = 3'b100;

  reg  [15:0]      flash_time;
  reg  [15:0]      wdog_time;
  reg  [NPORT-1:0] port_en;
  reg  [NCH-1:0]   cmd_reg;
  reg  [15:0]      cfg      [0:NCH-1];
  reg  [15:0]      on_time  [0:NCH-1];
  reg  [15:0]      off_time [0:NCH-1];
  reg  [15:0]      hold_time[0:NCH-1];
  reg  [15:0]      port_cnt [0:NPORT-1];
  reg  [NPORT-1:0] port_fail;
  reg  [NCH-1:0]   fail_hold;
  reg  [NCH-1:0]   fail_lvl;
  reg              comm_fail_q;

  reg              a_vld;
  reg              a_wr;
  reg  [7:0]       a_addr;
  reg  [31:0]      rd_mux;

  reg  [15:0]      tick_cnt;
  reg              tick;
  reg  [3:0]       fl_div;
  reg  [15:0]      fl_cnt;
  reg              flash_phase;

  wire             wr_en  = a_vld & a_wr;
  wire             cmd_wr = wr_en & (a_addr == `DOS_REG_CMD);
  wire             fail_rise = comm_fail & ~comm_fail_q;
  wire [15:0]      flash_lim = (flash_time == 16'h0000) ? 16'h0001 : flash_time;
  wire [NCH-1:0]   forced;
  wire [NCH-1:0]   cmd_wr_on;

  integer i;
  integer j;
  integer k;
  integer p;

  // Bus address phase capture; zero wait state, OKAY always
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_vld     <= 1'b0;
      a_wr      <= 1'b0;
      a_addr    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        a_vld  <= 1'b1;
        a_wr   <= hwrite;
        a_addr <= haddr[7:0];
        if (!hwrite)
          hrdata <= rd_mux;
      end else begin
        a_vld <= 1'b0;
      end
    end
  end

  // Read decode of the address phase; unmapped reads zero
  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `DOS_REG_FLASH:   rd_mux[15:0] = flash_time;
      `DOS_REG_WDOG:    rd_mux[15:0] = wdog_time;
      `DOS_REG_PORT_EN: rd_mux[NPORT-1:0] = port_en;
      `DOS_REG_STATUS: begin
        rd_mux[`DOS_ST_FAIL] = comm_fail;
        rd_mux[`DOS_ST_PORT_LSB +: NPORT] = port_fail;
        rd_mux[`DOS_ST_DOUT_LSB +: NCH]   = dout;
      end
      `DOS_REG_CMD:     rd_mux[NCH-1:0] = cmd_reg;
      default:          rd_mux = 32'h00000000;
    endcase
    for (k = 0; k < NCH; k = k + 1) begin
      if (haddr[7:4] == (`DOS_CH_BASE + k[3:0])) begin
        case (haddr[3:0])
          `DOS_CH_CFG:  rd_mux[15:0] = cfg[k];
          `DOS_CH_ON:   rd_mux[15:0] = on_time[k];
          `DOS_CH_OFF:  rd_mux[15:0] = off_time[k];
          `DOS_CH_HOLD: rd_mux[15:0] = hold_time[k];
          default:      rd_mux = 32'h00000000;
        endcase
      end
    end
  end

  // Register writes in the data phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flash_time <= `DOS_RST_FLASH;
      wdog_time  <= `DOS_RST_WDOG;
      port_en    <= {NPORT{1'b0}};
      cmd_reg    <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        cfg[i]       <= `DOS_RST_CFG;
        on_time[i]   <= 16'h0000;
        off_time[i]  <= 16'h0000;
        hold_time[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      if (a_addr == `DOS_REG_FLASH)
        flash_time <= hwdata[15:0];
      if (a_addr == `DOS_REG_WDOG)
        wdog_time <= hwdata[15:0];
      if (a_addr == `DOS_REG_PORT_EN)
        port_en <= hwdata[NPORT-1:0];
      for (i = 0; i < NCH; i = i + 1) begin
        if (cmd_wr && !forced[i])
          cmd_reg[i] <= hwdata[i];
        if (a_addr[7:4] == (`DOS_CH_BASE + i[3:0])) begin
          case (a_addr[3:0])
            `DOS_CH_CFG:  cfg[i] <= hwdata[15:0] & `DOS_CFG_MASK;
            `DOS_CH_ON:   on_time[i] <= hwdata[15:0];
            `DOS_CH_OFF:  off_time[i] <= hwdata[15:0];
            `DOS_CH_HOLD: hold_time[i] <= hwdata[15:0];
            default:      on_time[i] <= on_time[i];
          endcase
        end
      end
    end
  end

  // Shared millisecond tick and common flash timebase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt    <= 16'h0000;
      tick        <= 1'b0;
      fl_div      <= 4'h0;
      fl_cnt      <= 16'h0000;
      flash_phase <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (tick_cnt >= TICK_CYCLES - 16'h0001) begin
        tick_cnt <= 16'h0000;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
      if (tick) begin
        if (fl_div == `DOS_FLASH_STEP_MS) begin
          fl_div <= 4'h0;
          if (fl_cnt + 16'h0001 >= flash_lim) begin
            fl_cnt      <= 16'h0000;
            flash_phase <= ~flash_phase;
          end else begin
            fl_cnt <= fl_cnt + 16'h0001;
          end
        end else begin
          fl_div <= fl_div + 4'h1;
        end
      end
    end
  end

  // Link watchdog per port and failure state capture
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_fail   <= {NPORT{1'b0}};
      comm_fail   <= 1'b0;
      comm_fail_q <= 1'b0;
      fail_hold   <= {NCH{1'b0}};
      fail_lvl    <= {NCH{1'b0}};
      for (p = 0; p < NPORT; p = p + 1)
        port_cnt[p] <= 16'h0000;
    end else begin
      for (p = 0; p < NPORT; p = p + 1) begin
        if (msg_rx[p])
          port_cnt[p] <= 16'h0000;
        else if (tick && port_cnt[p] != 16'hFFFF)
          port_cnt[p] <= port_cnt[p] + 16'h0001;
        port_fail[p] <= port_en[p] && (wdog_time != 16'h0000) && !msg_rx[p] &&
                        (port_cnt[p] >= wdog_time);
      end
      comm_fail   <= |port_fail;
      comm_fail_q <= comm_fail;
      for (j = 0; j < NCH; j = j + 1) begin
        if (fail_rise && cfg[j][`DOS_CFG_FAIL_MSB:`DOS_CFG_FAIL_LSB] != `DOS_FAIL_HOLD) begin
          fail_hold[j] <= 1'b1;
          fail_lvl[j]  <= (cfg[j][`DOS_CFG_FAIL_MSB:`DOS_CFG_FAIL_LSB] == `DOS_FAIL_ON);
        end else if (cmd_wr) begin
          fail_hold[j] <= 1'b0;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire [2:0] mode  = cfg[g][`DOS_CFG_MODE_MSB:`DOS_CFG_MODE_LSB];
      wire [1:0] frc   = cfg[g][`DOS_CFG_FORCE_MSB:`DOS_CFG_FORCE_LSB];
      wire       src   = cfg[g][`DOS_CFG_SRC];
      wire       cmd   = src ? fb_result[g] : cmd_reg[g];
      reg        cmd_q;
      reg        phase;
      reg        tgl;
      reg        os_act;
      reg  [2:0] pstate;
      reg  [15:0] tmr;
      reg  [15:0] off_cnt;
      reg        want;
      reg        dq;
      wire       rise   = cmd & ~cmd_q;
      wire       refire = src ? rise : cmd_wr_on[g];
      wire       allow  = (hold_time[g] == 16'h0000) || (off_cnt >= hold_time[g]);
      wire [15:0] tmr_inc = (tmr == 16'hFFFF) ? tmr : tmr + 16'h0001;

      assign forced[g]    = (frc != `DOS_FORCE_NONE);
      assign dout[g]      = dq;
      assign cmd_wr_on[g] = cmd_wr & hwdata[g] & ~forced[g];

      always @* begin
        case (mode)
          `DOS_MODE_PWM:    want = cmd & phase;
          `DOS_MODE_DELAY:  want = cmd & (tmr >= off_time[g]);
          `DOS_MODE_FLASH:  want = cmd & flash_phase;
          `DOS_MODE_TOGGLE: want = tgl;
          `DOS_MODE_OSALT:  want = tgl;
          `DOS_MODE_PULSE:  want = (pstate == S_ON);
          default:          want = cmd;
        endcase
      end

      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cmd_q   <= 1'b0;
          phase   <= 1'b1;
          tgl     <= 1'b0;
          os_act  <= 1'b0;
          pstate  <= S_IDLE;
          tmr     <= 16'h0000;
          off_cnt <= 16'hFFFF;
          dq      <= 1'b0;
        end else begin
          cmd_q <= cmd;
          case (mode)
            `DOS_MODE_PWM: begin
              if (!cmd) begin
                phase <= 1'b1;
                tmr   <= 16'h0000;
              end else if (tick) begin
                if (tmr_inc >= (phase ? on_time[g] : off_time[g])) begin
                  phase <= ~phase;
                  tmr   <= 16'h0000;
                end else begin
                  tmr <= tmr_inc;
                end
              end
            end
            `DOS_MODE_DELAY: begin
              if (!cmd)
                tmr <= 16'h0000;
              else if (tick)
                tmr <= tmr_inc;
            end
            `DOS_MODE_TOGGLE: begin
              if (rise)
                tgl <= ~tgl;
            end
            `DOS_MODE_OSALT: begin
              if (rise) begin
                tgl    <= ~tgl;
                os_act <= ~tgl;
                tmr    <= 16'h0000;
              end else if (os_act && tick) begin
                if (tmr_inc >= on_time[g]) begin
                  tgl    <= 1'b0;
                  os_act <= 1'b0;
                end else begin
                  tmr <= tmr_inc;
                end
              end
            end
            `DOS_MODE_PULSE: begin
              case (pstate)
                S_IDLE: begin
                  if (refire) begin
                    pstate <= S_WAIT;
                    tmr    <= 16'h0000;
                  end
                end
                S_WAIT: begin
                  if (refire)
                    tmr <= 16'h0000;
                  else if (tmr >= off_time[g]) begin
                    pstate <= S_ON;
                    tmr    <= 16'h0000;
                  end else if (tick)
                    tmr <= tmr_inc;
                end
                S_ON: begin
                  if (refire)
                    tmr <= 16'h0000;
                  else if (tmr >= on_time[g])
                    pstate <= S_IDLE;
                  else if (tick)
                    tmr <= tmr_inc;
                end
                default: pstate <= S_IDLE;
              endcase
            end
            default: begin
              tmr    <= 16'h0000;
              phase  <= 1'b1;
              pstate <= S_IDLE;
              os_act <= 1'b0;
            end
          endcase
          // Time spent off, saturating, for restart lockout
          if (dq)
            off_cnt <= 16'h0000;
          else if (tick && off_cnt != 16'hFFFF)
            off_cnt <= off_cnt + 16'h0001;
          if (frc == `DOS_FORCE_ON)
            dq <= 1'b1;
          else if (frc == `DOS_FORCE_OFF)
            dq <= 1'b0;
          else if (fail_hold[g])
            dq <= fail_lvl[g] & (dq | allow);
          else
            dq <= want & (dq | allow);
        end
      end
    end
  endgenerate

endmodule // dos_sequencer
`default_nettype wire

/* sim/dos_chk.sv */
// Checker: bus and channel 0 assertions for the sequencer.
// Assumes hready is hreadyout and a single bus master.
`timescale 1ns/10ps
`default_nettype none
module dos_chk #(
  parameter        NCH         = 4,
  parameter        NPORT       = 2,
  parameter [15:0] TICK_CYCLES = 16'h4E20
) (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic [NPORT-1:0] msg_rx,
  input wire logic [NCH-1:0]   fb_result,
  input wire logic [NCH-1:0]   dout,
  input wire logic             comm_fail
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic        wr_p;
  logic [7:0]  a_p;
  logic [13:0] cfg0;
  logic [15:0] wdog;
  logic [1:0]  pen;
  logic [31:0] quiet;
  // Mirror of the registers the properties depend on
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_p  <= 1'b0;
      a_p   <= 8'h00;
      cfg0  <= 14'h0000;
      wdog  <= 16'h0000;
      pen   <= 2'h0;
      quiet <= 32'h0;
    end else begin
      quiet <= msg_rx[0] ? 32'h0 : quiet + 32'h1;
      if (hready) begin
        wr_p <= hsel & htrans[1] & hwrite;
        a_p  <= haddr[7:0];
      end
      if (hready && wr_p && a_p == 8'h04) wdog <= hwdata[15:0];
      if (hready && wr_p && a_p == 8'h08) pen <= hwdata[1:0];
      if (hready && wr_p && a_p == 8'h40) cfg0 <= hwdata[13:0];
    end
  end
  sequence s_msg0; pen == 2'h1 && msg_rx[0]; endsequence
  sequence s_src; (cfg0[8] && cfg0[5:0] == 6'h00 && !comm_fail) [*2]; endsequence
  property p_ready; $past(rstn) |-> hreadyout; endproperty
  property p_f_on; (cfg0[5:4] == 2'h2) [*2] |-> dout[0]; endproperty
  property p_f_off; (cfg0[5:4] == 2'h1) [*2] |-> !dout[0]; endproperty
  property p_src; s_src |-> dout[0] == $past(fb_result[0]); endproperty
  property p_no_wd; (wdog == 16'h0000) [*4] |-> !comm_fail; endproperty
  property p_no_port; (pen == 2'h0) [*4] |-> !comm_fail; endproperty
  property p_clear; s_msg0 |-> ##[1:4] !comm_fail; endproperty
  property p_late;
    $rose(comm_fail) && pen == 2'h1 && $stable(wdog) |-> quiet >= (wdog - 1) * TICK_CYCLES;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready");
  a_f_on: assert property (p_f_on) else $error("forced on lost");
  a_f_off: assert property (p_f_off) else $error("forced off lost");
  a_src: assert property (p_src) else $error("source not followed");
  a_no_wd: assert property (p_no_wd) else $error("fail with zero timeout");
  a_no_port: assert property (p_no_port) else $error("fail on disabled port");
  a_clear: assert property (p_clear) else $error("fail kept after message");
  a_late: assert property (p_late) else $error("fail too early");
endmodule // dos_chk
bind dos_sequencer dos_chk #(.NCH(NCH), .NPORT(NPORT), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .msg_rx(msg_rx), .fb_result(fb_result), .dout(dout), .comm_fail(comm_fail));
`default_nettype wire

/* sim/dos_host.sv */
// Host model: message pulses on both ports every 32 clocks.
// Assumes alive from the bench stops the traffic.
`timescale 1ns/10ps
`default_nettype none
module dos_host (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       alive,
  output logic      [1:0] msg_rx
);
  logic [4:0] n;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n      <= 5'h00;
      msg_rx <= 2'h0;
    end else begin
      n      <= n + 5'h01;
      msg_rx <= {2{alive && n == 5'h00}};
    end
  end
endmodule // dos_host
`default_nettype wire

/* sim/dos_sequencer_tb.sv */
// Testbench: drives the sequencer over AHB-Lite and checks its outputs.
// Assumes a 1 ms tick of 20 clocks and the heartbeat host model.
`timescale 1ns/10ps
`default_nettype none
module dos_sequencer_tb;
  logic        clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [1:0]  msg_rx;
  logic [3:0]  fb;
  logic [3:0]  dout;
  logic        comm_fail;
  logic        alive;
  logic [31:0] seed;
  logic [31:0] q;
  int          err_total;
  int          checked;
  int          n;
  int          s;
  dos_sequencer #(.TICK_CYCLES(16'h0014)) u_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .msg_rx(msg_rx),
    .fb_result(fb), .dout(dout), .comm_fail(comm_fail));
  dos_host u_host (.clk(clk), .rstn(rstn), .alive(alive), .msg_rx(msg_rx));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ch(input int i, input int o);
    return 8'h40 + 8'(16 * i + o);
  endfunction
  function automatic logic [31:0] st(input logic f, input logic [1:0] p, input logic [3:0] d);
    return {12'h000, d, 6'h00, p, 7'h00, f};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    checked++;
    if (sv !== ev) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  // Timing tolerance of one tick plus bus cycles
  task automatic near(input string nm, input int sv, input int ev);
    chk(nm, (sv > ev - 25 && sv < ev + 25) ? ev : sv, ev);
  endtask
  task automatic rdy();
    s = 0;
    do begin
      @(posedge clk);
      s++;
    end while (hreadyout !== 1'b1 && s < 50);
    if (s >= 50) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic r(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
    chk("resp", hresp, 1'b0);
  endtask
  task automatic tl(input int c, input logic lv);
    n = 0;
    while (dout[c] !== lv && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      err_total++;
      summarize();
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    seed = 32'h000089C3;
    err_total = 0;
    checked = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fb = 4'h0;
    alive = 1'b1;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    r("flash", 8'h00, 32'h00000032);
    r("wdog", 8'h04, 32'h0);
    r("cmd", 8'h10, 32'h0);
    r("hole", 8'hF0, 32'h0);
    w(ch(3, 0), 32'hFFFFCEC0);
    r("rsvd", ch(3, 0), 32'h0);
    w(8'h00, 32'hFFFFFFFF);
    r("fl_max", 8'h00, 32'h0000FFFF);
    $display("test regs done");
    w(ch(0, 0), 32'h00000020);
    repeat (2) @(posedge clk);
    chk("f_on", dout[0], 1'b1);
    w(8'h10, 32'h1);
    w(ch(0, 0), 32'h00000010);
    repeat (2) @(posedge clk);
    chk("f_off", dout[0], 1'b0);
    r("f_keep", ch(0, 0), 32'h00000010);
    w(ch(0, 0), 32'h0);
    repeat (2) @(posedge clk);
    chk("f_drop", dout[0], 1'b0);
    w(ch(0, 0), 32'h00000100);
    for (int i = 0; i < 16; i++) begin
      fb <= 4'(xs());
      repeat (3) @(posedge clk);
      chk("src", dout[0], fb[0]);
    end
    w(ch(0, 0), 32'h0);
    $display("test force and source done");
    w(ch(1, 12), 32'h5);
    w(8'h10, 32'h2);
    w(8'h10, 32'h0);
    w(8'h10, 32'h2);
    tl(1, 1'b1);
    near("ho_wait", n, 97);
    w(8'h10, 32'h0);
    repeat (150) @(posedge clk);
    w(8'h10, 32'h2);
    tl(1, 1'b1);
    chk("ho_none", n < 4, 1'b1);
    w(8'h10, 32'h0);
    w(ch(1, 12), 32'h0);
    $display("test holdoff done");
    w(ch(3, 0), 32'h1);
    w(ch(3, 4), 32'h2);
    w(ch(3, 8), 32'h3);
    w(8'h10, 32'h8);
    tl(3, 1'b1);
    tl(3, 1'b0);
    near("pwm_on", n, 40);
    tl(3, 1'b1);
    near("pwm_off", n, 60);
    w(ch(2, 0), 32'h2);
    w(ch(2, 8), 32'h3);
    w(8'h10, 32'h4);
    tl(2, 1'b1);
    near("dly", n, 60);
    repeat (200) @(posedge clk);
    chk("dly_hold", dout[3:2], 2'h1);
    w(ch(2, 0), 32'h6);
    w(ch(2, 4), 32'h2);
    w(8'h10, 32'h4);
    tl(2, 1'b1);
    tl(2, 1'b0);
    near("pl_on", n, 40);
    w(8'h10, 32'h4);
    tl(2, 1'b1);
    near("pl_again", n, 60);
    repeat (20) @(posedge clk);
    w(8'h10, 32'h4);
    tl(2, 1'b0);
    near("pl_retrig", n, 40);
    $display("test timed modes done");
    w(8'h10, 32'h0);
    w(ch(3, 0), 32'h4);
    for (int i = 0; i < 4; i++) begin
      w(8'h10, {28'h0, 1'(4'hB >> i), 3'h0});
      // Toggle state adds one register stage before the output
      repeat (3) @(posedge clk);
      chk("toggle", dout[3], 4'h7 >> i & 4'h1);
    end
    w(ch(3, 0), 32'h5);
    w(8'h10, 32'h0);
    w(8'h10, 32'h8);
    tl(3, 1'b1);
    tl(3, 1'b0);
    near("os_len", n, 38);
    w(8'h10, 32'h0);
    $display("test toggle done");
    w(8'h00, 32'h1);
    w(ch(1, 0), 32'h3);
    w(ch(2, 0), 32'h3);
    w(8'h10, 32'h2);
    tl(1, 1'b0);
    tl(1, 1'b1);
    tl(1, 1'b0);
    near("fl_half", n, 200);
    repeat (50) @(posedge clk);
    w(8'h10, 32'h6);
    repeat (2) @(posedge clk);
    s = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      s += int'(dout[1] !== dout[2]);
    end
    chk("fl_sync", s, 0);
    w(8'h10, 32'h0);
    $display("test flash done");
    w(ch(1, 0), 32'h00002000);
    w(ch(2, 0), 32'h00001000);
    w(8'h10, 32'h4);
    w(8'h04, 32'h3);
    w(8'h08, 32'h1);
    repeat (300) @(posedge clk);
    chk("cf_quiet", comm_fail, 1'b0);
    alive <= 1'b0;
    n = 0;
    while (comm_fail !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("cf_time", n < 100, 1'b1);
    repeat (3) @(posedge clk);
    r("cf_stat", 8'h0C, st(1'b1, 2'h1, 4'h2));
    alive <= 1'b1;
    repeat (100) @(posedge clk);
    chk("cf_back", {comm_fail, dout}, 5'h02);
    w(8'h10, 32'h0);
    repeat (2) @(posedge clk);
    chk("cf_host", dout, 4'h0);
    w(8'h08, 32'h0);
    alive <= 1'b0;
    repeat (200) @(posedge clk);
    chk("cf_port", comm_fail, 1'b0);
    $display("test link loss done");
    summarize();
  end
endmodule // dos_sequencer_tb
`default_nettype wire
